// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import usss_pkg::*;
  // ----------------------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------------------
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         sleep = 1'b0;
  usss_wb_req_t req   = '0;
  logic [31:0]  dat;
  logic         ack, ck, m_dt, d_dt, oe_n, wake, irq;
  logic [8:0]   r;
  int           miscompares = 0;
  int           compares    = 0;
  int           cycles      = 0;
  // the pin is the device's while its enable is low, else the master's
  wire dt = oe_n ? m_dt : d_dt;
  usss_slave usss_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .ck_i(ck), .dt_i(dt), .dt_o(d_dt), .dt_oe_n_o(oe_n), .sleep_i(sleep),
    .wake_o(wake), .irq_o(irq));
  usss_master_model usss_master_model_inst (.clk_i(clk_i), .ck_o(ck), .dt_o(m_dt), .dt_i(dt));
  initial forever #20 clk_i = ~clk_i;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk_i) req <= {1'b1, 1'b1, we, a, 2'b00, 4'hF, 24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat[7:0];
    req <= '0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({1'b0, q}, {1'b0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    tick(20);
    rst_i <= 1'b0;
    rd(6'h05, 8'h02);
    rd(6'h0F, 8'h00);
    wr(6'h03, 8'h80);
    wr(6'h05, 8'h30);
    wr(6'h01, 8'h10);
    wr(6'h04, 8'hA5);
    wr(6'h04, 8'h3C);
    rd(6'h00, 8'h00);
    rd(6'h05, 8'h30);
    @(posedge clk_i) sleep <= 1'b1;
    tick(2);
    chk(wake, 1'b0);
    usss_master_model_inst.xfer(9'h000, 8, r);
    chk(r, 9'h0A5);
    tick(4);
    chk(wake, 1'b1);
    chk(irq, 1'b0);
    @(posedge clk_i) sleep <= 1'b0;
    wr(6'h08, 8'hC0);
    tick(2);
    chk(irq, 1'b1);
    wr(6'h00, 8'h00);
    rd(6'h00, 8'h10);
    usss_master_model_inst.xfer(9'h000, 8, r);
    chk(r, 9'h03C);
    tick(4);
    rd(6'h05, 8'h32);
    wr(6'h05, 8'h71);
    wr(6'h04, 8'h81);
    usss_master_model_inst.xfer(9'h000, 9, r);
    chk(r, 9'h181);
    wr(6'h05, 8'h10);
    wr(6'h01, 8'h20);
    wr(6'h03, 8'hB0);
    @(posedge clk_i) sleep <= 1'b1;
    usss_master_model_inst.xfer(9'h05A, 8, r);
    tick(6);
    chk(wake, 1'b1);
    @(posedge clk_i) sleep <= 1'b0;
    rd(6'h00, 8'h30);
    rd(6'h03, 8'hB0);
    rd(6'h07, 8'h5A);
    rd(6'h00, 8'h10);
    usss_master_model_inst.xfer(9'h066, 8, r);
    usss_master_model_inst.xfer(9'h099, 8, r);
    tick(6);
    rd(6'h03, 8'hB2);
    wr(6'h03, 8'h80);
    rd(6'h03, 8'h80);
    rd(6'h07, 8'h66);
    report_and_stop();
  end
endmodule

// [usss_master_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// external master: supplies the shift clock and shares the data line
// ----------------------------------------------------------------------------
module usss_master_model (
  input  wire logic clk_i,
  output logic      ck_o,
  output logic      dt_o,
  input  wire logic dt_i
);
  // clock stands high between frames, it never runs free
  initial begin
    ck_o = 1'b1;
    dt_o = 1'b1;
  end
  // one frame, lsb first; r holds the wire level seen at each falling edge
  task automatic xfer(input logic [8:0] w, input int n, output logic [8:0] r);
    // pin edges fall between core clock edges so they never race the sampler
    @(negedge clk_i);
    r = '0;
    for (int i = 0; i < n; i++) begin
      dt_o = w[i];      // data only changes after a rising edge
      #160 ck_o = 1'b0; // the master alone makes the clock
      r[i] = dt_i;
      #160 ck_o = 1'b1;
    end
    // a released line must not keep showing the last bit
    dt_o = ~dt_o;
  endtask
endmodule

// [usss_pkg.sv]
package usss_pkg;
  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } usss_wb_req_t;
  // transmit shift register occupancy
  typedef enum logic [1:0] {
    USSS_TX_IDLE  = 2'b01,
    USSS_TX_SHIFT = 2'b10
  } usss_tx_state_t;
endpackage

// [usss_regs.svh]
`ifndef USSS_REGS_SVH
`define USSS_REGS_SVH
// ----------------------------------------------------------------------------
// register word indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define USSS_IDX_FLAGS    6'h00
`define USSS_IDX_ENABLES  6'h01
`define USSS_IDX_PRIO     6'h02
`define USSS_IDX_RXCTL    6'h03
`define USSS_IDX_TXHOLD   6'h04
`define USSS_IDX_TXCTL    6'h05
`define USSS_IDX_BAUD     6'h06
`define USSS_IDX_RXHOLD   6'h07
`define USSS_IDX_INTCTL   6'h08
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define USSS_B_RX_FLAG    5
`define USSS_B_TX_FLAG    4
`define USSS_B_PORT_EN    7
`define USSS_B_NINE_RX    6
`define USSS_B_SINGLE_RX  5
`define USSS_B_CONT_RX    4
`define USSS_B_OVERRUN    1
`define USSS_B_CLK_SRC    7
`define USSS_B_NINE_TX    6
`define USSS_B_TX_EN      5
`define USSS_B_SYNC       4
`define USSS_B_SR_EMPTY   1
`define USSS_B_TX_BIT8    0
`define USSS_B_GLOBAL_IE  7
`define USSS_B_PERIPH_IE  6
// ----------------------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------------------
`define USSS_RST_ZERO     8'h00
`define USSS_RST_TXCTL    8'h02
`define USSS_WM_FLAGS     8'hCF
`define USSS_WM_RXCTL     8'hF8
`define USSS_WM_TXCTL     8'hF5
`define USSS_WM_INTCTL    8'hC0
// ----------------------------------------------------------------------------
// word lengths in bits
// ----------------------------------------------------------------------------
`define USSS_BITS_8       4'h8
`define USSS_BITS_9       4'h9
`endif

// [usss_shift.sv]
`timescale 1ns/1ns
module usss_shift #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_data_i,
  input  wire logic             shift_i,
  input  wire logic             serial_i,
  output logic      [WIDTH-1:0] q_o
);
  // ----------------------------------------------------------------------------
  // lsb-first shift register, new bit enters at the top
  // ----------------------------------------------------------------------------
  if (WIDTH < 2) begin : g_bad_width
    $error("usss_shift needs at least two bits");
  end

  // load wins over shift so a fresh word is never half shifted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else if (load_i) begin
      q_o <= load_data_i;
    end else if (shift_i) begin
      q_o <= {serial_i, q_o[WIDTH-1:1]};
    end
  end
endmodule

// [usss_slave.sv]
`timescale 1ns/1ns
`include "usss_regs.svh"
module usss_slave (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire usss_pkg::usss_wb_req_t wb_req_i,
  output logic                 [31:0] wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   ck_i,
  input  wire logic                   dt_i,
  output logic                        dt_o,
  output logic                        dt_oe_n_o,
  input  wire logic                   sleep_i,
  output logic                        wake_o,
  output logic                        irq_o
);
  import usss_pkg::*;

  // ----------------------------------------------------------------------------
  // pin synchronisers and shift clock edges
  // ----------------------------------------------------------------------------
  logic [1:0] pin_s;        // {data, clock} after two stages
  logic       ck_s;         // synchronised shift clock
  logic       dt_s;         // synchronised data pin
  logic       ck_d_reg;     // shift clock one cycle later
  logic       ck_rise;      // rising edge seen on shift clock
  logic       ck_fall;      // falling edge seen on shift clock

  // the shift clock comes from the far master and is never made here
  usss_sync #(
    .W (2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({dt_i, ck_i}),
    .q_o   (pin_s)
  );

  assign ck_s    = pin_s[0];
  assign dt_s    = pin_s[1];
  assign ck_rise = ck_s & ~ck_d_reg;
  assign ck_fall = ~ck_s & ck_d_reg;

  // edge detector reads only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_d_reg <= 1'b0;
    end else begin
      ck_d_reg <= ck_s;
    end
  end

  // ----------------------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------------------
  logic       req;          // new access, not yet answered
  logic       wr;           // write on the low byte lane
  logic       rd;           // read access
  logic [5:0] idx;          // word index
  logic [7:0] wdat;         // low byte of write data

  assign req  = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wr   = req & wb_req_i.we & wb_req_i.sel[0];
  assign rd   = req & ~wb_req_i.we;
  assign idx  = wb_req_i.adr[7:2];
  assign wdat = wb_req_i.dat[7:0];

  // ----------------------------------------------------------------------------
  // software control registers
  // ----------------------------------------------------------------------------
  logic [7:0] flags_reg;    // other peripherals' flags, storage only
  logic [7:0] enables_reg;  // per-source interrupt enables
  logic [7:0] prio_reg;     // priority bits, storage only
  logic [7:0] rxctl_reg;    // receive control, bits 7:3 writable
  logic [7:0] txctl_reg;    // transmit control, live bits kept zero
  logic [7:0] baud_reg;     // divisor, unused while slave
  logic [7:0] intctl_reg;   // global and peripheral enables

  // plain storage; live status bits are merged on read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg   <= `USSS_RST_ZERO;
      enables_reg <= `USSS_RST_ZERO;
      prio_reg    <= `USSS_RST_ZERO;
      rxctl_reg   <= `USSS_RST_ZERO;
      txctl_reg   <= `USSS_RST_ZERO;
      baud_reg    <= `USSS_RST_ZERO;
      intctl_reg  <= `USSS_RST_ZERO;
    end else if (wr) begin
      case (idx)
        `USSS_IDX_FLAGS:   flags_reg   <= wdat & `USSS_WM_FLAGS;
        `USSS_IDX_ENABLES: enables_reg <= wdat;
        `USSS_IDX_PRIO:    prio_reg    <= wdat;
        `USSS_IDX_RXCTL:   rxctl_reg   <= wdat & `USSS_WM_RXCTL;
        `USSS_IDX_TXCTL:   txctl_reg   <= wdat & `USSS_WM_TXCTL;
        `USSS_IDX_BAUD:    baud_reg    <= wdat;
        `USSS_IDX_INTCTL:  intctl_reg  <= wdat & `USSS_WM_INTCTL;
        default: begin
          // other indices have no storage here
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------------------
  logic mode_ok;            // synchronous slave selected
  logic tx_on;              // transmitter running
  logic rx_on;              // receiver running
  logic nine_tx;            // nine-bit transmit
  logic nine_rx;            // nine-bit receive
  logic cont_rx;            // continuous receive enable
  logic overrun_error_flag_reg;           // overrun error

  assign mode_ok = rxctl_reg[`USSS_B_PORT_EN] & txctl_reg[`USSS_B_SYNC]
                 & ~txctl_reg[`USSS_B_CLK_SRC];
  assign tx_on   = mode_ok & txctl_reg[`USSS_B_TX_EN];
  assign cont_rx = rxctl_reg[`USSS_B_CONT_RX];
  // single receive enable deliberately left out of the term
  assign rx_on   = mode_ok & cont_rx & ~overrun_error_flag_reg;
  assign nine_tx = txctl_reg[`USSS_B_NINE_TX];
  assign nine_rx = rxctl_reg[`USSS_B_NINE_RX];

  // ----------------------------------------------------------------------------
  // transmit holding register and empty flag
  // ----------------------------------------------------------------------------
  logic           hold_wr;        // software writes the holding register
  logic           tx_load;        // holding word moves to shift register
  logic [7:0]     hold_reg;       // holding data
  logic           hold_full_reg;  // holding register owns a word
  logic           transmit_buffer_empty_flag_reg;       // transmit buffer empty flag
  usss_tx_state_t tx_state_reg;   // shift register occupancy
  logic [3:0]     tx_cnt_reg;     // bits still to leave
  logic           tx_adv_reg;     // a bit was taken, next on rising edge
  logic [8:0]     tsr_q;          // transmit shift register

  assign hold_wr = wr & (idx == `USSS_IDX_TXHOLD);
  // load as soon as the shift register is empty, even mid-sleep
  assign tx_load = tx_on & hold_full_reg & (tx_state_reg == USSS_TX_IDLE);

  // holding data; a write in the load cycle keeps the new word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg      <= `USSS_RST_ZERO;
      hold_full_reg <= 1'b0;
    end else if (hold_wr) begin
      hold_reg      <= wdat;
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  // a write in the transfer cycle leaves the buffer full, so the clear wins there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_buffer_empty_flag_reg <= 1'b0;
    end else if (hold_wr) begin
      transmit_buffer_empty_flag_reg <= 1'b0;
    end else if (tx_load) begin
      transmit_buffer_empty_flag_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // transmit shift sequencing
  // ----------------------------------------------------------------------------
  // ninth bit is taken from control at load time
  usss_shift #(
    .WIDTH (9)
  ) u_tsr (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (tx_load),
    .load_data_i ({nine_tx & txctl_reg[`USSS_B_TX_BIT8], hold_reg}),
    .shift_i     (tx_adv_reg & ck_rise),
    .serial_i    (1'b0),
    .q_o         (tsr_q)
  );

  // each falling clock edge retires one bit; the last one frees the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= USSS_TX_IDLE;
      tx_cnt_reg   <= 4'h0;
      tx_adv_reg   <= 1'b0;
    end else begin
      case (tx_state_reg)
        USSS_TX_IDLE: begin
          tx_adv_reg <= 1'b0;
          if (tx_load) begin
            tx_state_reg <= USSS_TX_SHIFT;
            tx_cnt_reg   <= nine_tx ? `USSS_BITS_9 : `USSS_BITS_8;
          end
        end
        USSS_TX_SHIFT: begin
          if (!tx_on) begin
            // dropping the enable abandons the word
            tx_state_reg <= USSS_TX_IDLE;
            tx_cnt_reg   <= 4'h0;
          end else if (ck_fall) begin
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            tx_adv_reg <= 1'b1;
            if (tx_cnt_reg == 4'h1) begin
              tx_state_reg <= USSS_TX_IDLE;
            end
          end else if (ck_rise) begin
            tx_adv_reg <= 1'b0;
          end
        end
        default: begin
          tx_state_reg <= USSS_TX_IDLE;
        end
      endcase
    end
  end

  // data pin: driven (enable low) whenever the transmitter is on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt_o      <= 1'b0;
      dt_oe_n_o <= 1'b1;
    end else begin
      dt_o      <= tsr_q[0];
      dt_oe_n_o <= ~tx_on;
    end
  end

  // ----------------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------------
  logic [3:0] rx_cnt_reg;    // bits gathered so far
  logic       rx_last;       // this falling edge takes the final bit
  logic       rx_done_reg;   // word complete, shift register settled
  logic [8:0] rsr_q;         // receive shift register
  logic [7:0] rxhold_reg;    // received data
  logic       rx_bit8_reg;   // received ninth bit
  logic       receive_complete_flag_reg;      // receive complete flag
  logic       rxhold_rd;     // software reads received data
  logic       overrun;       // new word while the last is unread

  assign rx_last   = rx_cnt_reg == (nine_rx ? `USSS_BITS_9 : `USSS_BITS_8) - 4'h1;
  assign rxhold_rd = rd & (idx == `USSS_IDX_RXHOLD);
  assign overrun   = rx_done_reg & receive_complete_flag_reg;

  // the receiver is cleared whenever it is off
  usss_shift #(
    .WIDTH (9)
  ) u_rsr (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .load_i      (~rx_on),
    .load_data_i (9'h000),
    .shift_i     (rx_on & ck_fall),
    .serial_i    (dt_s),
    .q_o         (rsr_q)
  );

  // bit counter advances only on falling shift clock edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_reg  <= 4'h0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= rx_on & ck_fall & rx_last;
      if (!rx_on) begin
        rx_cnt_reg <= 4'h0;
      end else if (ck_fall) begin
        rx_cnt_reg <= rx_last ? 4'h0 : rx_cnt_reg + 4'h1;
      end
    end
  end

  // transfer to holding register unless the last word is unread
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxhold_reg  <= `USSS_RST_ZERO;
      rx_bit8_reg <= 1'b0;
    end else if (rx_done_reg && !receive_complete_flag_reg) begin
      rxhold_reg  <= nine_rx ? rsr_q[7:0] : rsr_q[8:1];
      rx_bit8_reg <= nine_rx & rsr_q[8];
    end
  end

  // completion set wins over the clearing read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_complete_flag_reg <= 1'b0;
    end else if (rx_done_reg && !receive_complete_flag_reg) begin
      receive_complete_flag_reg <= 1'b1;
    end else if (rxhold_rd) begin
      receive_complete_flag_reg <= 1'b0;
    end
  end

  // overrun sticks until continuous receive is cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_error_flag_reg <= 1'b0;
    end else if (!cont_rx) begin
      overrun_error_flag_reg <= 1'b0;
    end else if (overrun) begin
      overrun_error_flag_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // wake and interrupt outputs
  // ----------------------------------------------------------------------------
  logic tx_pend;    // enabled transmit request
  logic rx_pend;    // enabled receive request

  // the shift-empty bit feeds neither term
  assign tx_pend = transmit_buffer_empty_flag_reg & enables_reg[`USSS_B_TX_FLAG];
  assign rx_pend = receive_complete_flag_reg & enables_reg[`USSS_B_RX_FLAG];

  // wake needs only the source enable; the vector needs both globals
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
      irq_o  <= 1'b0;
    end else begin
      wake_o <= sleep_i & (tx_pend | rx_pend);
      irq_o  <= (tx_pend | rx_pend) & intctl_reg[`USSS_B_GLOBAL_IE]
              & intctl_reg[`USSS_B_PERIPH_IE];
    end
  end

  // ----------------------------------------------------------------------------
  // read mux and bus answer
  // ----------------------------------------------------------------------------
  logic [7:0] rd_data;   // selected register byte

  always_comb begin
    rd_data = 8'h00;
    case (idx)
      `USSS_IDX_FLAGS:   rd_data = {flags_reg[7:6], receive_complete_flag_reg, transmit_buffer_empty_flag_reg, flags_reg[3:0]};
      `USSS_IDX_ENABLES: rd_data = enables_reg;
      `USSS_IDX_PRIO:    rd_data = prio_reg;
      // framing error cannot occur without start and stop bits
      `USSS_IDX_RXCTL:   rd_data = {rxctl_reg[7:3], 1'b0, overrun_error_flag_reg, rx_bit8_reg};
      `USSS_IDX_TXHOLD:  rd_data = hold_reg;
      `USSS_IDX_TXCTL:   rd_data = {txctl_reg[7:2], tx_state_reg == USSS_TX_IDLE,
                                    txctl_reg[0]};
      `USSS_IDX_BAUD:    rd_data = baud_reg;
      `USSS_IDX_RXHOLD:  rd_data = rxhold_reg;
      `USSS_IDX_INTCTL:  rd_data = intctl_reg;
      default:           rd_data = 8'h00;
    endcase
  end

  // one wait state; unmapped words answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bus_ack_one: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
  a_load_at_once: assert property (hold_full_reg && tx_on && tx_state_reg == USSS_TX_IDLE
    |=> tx_state_reg == USSS_TX_SHIFT)
    else $error("idle shift register did not take held word");
  a_second_waits: assert property (tx_state_reg == USSS_TX_SHIFT && hold_full_reg
    && tx_cnt_reg > 4'h1 |=> hold_full_reg && !transmit_buffer_empty_flag_reg)
    else $error("second word left early or empty flag rose");
  a_flag_on_load: assert property (tx_load |=> transmit_buffer_empty_flag_reg && !hold_full_reg || hold_full_reg
    && $past(hold_wr))
    else $error("empty flag not set after transfer");
  a_flag_no_clear: assert property (transmit_buffer_empty_flag_reg && !hold_wr |=> transmit_buffer_empty_flag_reg)
    else $error("empty flag cleared without holding write");
  a_wake_on_tx: assert property (sleep_i && transmit_buffer_empty_flag_reg && enables_reg[`USSS_B_TX_FLAG]
    |=> wake_o)
    else $error("enabled transmit flag did not wake core");
  a_vector_gated: assert property (irq_o |-> $past(intctl_reg[`USSS_B_GLOBAL_IE]))
    else $error("interrupt raised with global enable clear");
  a_rx_transfer: assert property (rx_done_reg && !receive_complete_flag_reg && !nine_rx
    |=> receive_complete_flag_reg && rxhold_reg == $past(rsr_q[8:1]))
    else $error("received word not moved to holding register");
  a_rx_fall_only: assert property (rx_on && $past(rx_on) && rx_cnt_reg != $past(rx_cnt_reg)
    |-> $past(ck_fall))
    else $error("receive bit taken without falling clock edge");
  a_err_cleared: assert property (!cont_rx |=> !overrun_error_flag_reg)
    else $error("overrun not cleared with continuous receive off");
  a_empty_bit: assert property (tx_state_reg == USSS_TX_IDLE |-> tx_cnt_reg == 4'h0
    || $past(!tx_on))
    else $error("shift register idle with bits left");

  c_two_words: cover property (tx_state_reg == USSS_TX_SHIFT && hold_full_reg ##[1:1000]
    tx_load);
  c_rx_word: cover property (rx_done_reg ##1 receive_complete_flag_reg);
  c_overrun: cover property (overrun);
  c_wake: cover property (sleep_i ##1 wake_o);
endmodule

// [usss_sync.sv]
`timescale 1ns/1ns
module usss_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // ----------------------------------------------------------------------------
  // two flip-flops per bit
  // ----------------------------------------------------------------------------
  logic [W-1:0] meta_reg;   // first stage, read only by the second

  if (W < 1) begin : g_bad_w
    $error("usss_sync needs at least one bit");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    // each pin bit passes its own pair of stages
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_reg[i] <= 1'b0;
        q_o[i]      <= 1'b0;
      end else begin
        meta_reg[i] <= d_i[i];
        q_o[i]      <= meta_reg[i];
      end
    end
  end
endmodule
